// ===== dic_pkg.sv
// constants and carrier types for the discrete input conditioning block
`default_nettype none
package dic_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ASSIGN = 8'h04;
  localparam logic [7:0] ADDR_PROG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_ANALOG = 8'h10;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_W = 13;
  localparam logic [12:0] CTRL_RESET = 13'h04ff;
  localparam int ASG_W = 5;
  localparam int ASG_DEFHOME_LSB = 0;
  localparam int ASG_HWRST_LSB = 8;
  localparam int ASG_KILL_LSB = 16;
  localparam logic [4:0] ASG_OFF = 5'h00;
  localparam logic [4:0] ASG_MAX = 5'h10;
  localparam int PRG_DEB_LSB = 0;
  localparam int PRG_LINES_LSB = 8;
  localparam int PRG_DEF_LSB = 16;
  localparam int ST_PROG_LSB = 16;
  localparam int ST_EXP_BIT = 24;
  localparam int AN_FEED_LSB = 16;

  // ---------------------------------------------------------------
  // input pin positions (pin n sits at index n-1)
  // ---------------------------------------------------------------
  localparam int NUM_IN = 16;
  localparam int PIN_LIM_FWD = 0;
  localparam int PIN_LIM_REV = 1;
  localparam int PIN_DRIVE = 2;
  localparam int PIN_START = 3;
  localparam int PIN_HOME_SW = 4;
  localparam int PIN_HOME_CMD = 5;
  localparam int PIN_JOG_FWD = 6;
  localparam int PIN_JOG_REV = 7;
  localparam int PIN_PAUSE = 8;
  localparam int PIN_EMERG = 9;
  localparam int PIN_INT_ONE = 10;
  localparam int PIN_INT_TWO = 11;
  localparam int SEL_LSB_PIN = 10;
  localparam int SEL_MAX = 6;
  localparam logic [15:0] DEDICATED_MASK = 16'h03ff;

  // ---------------------------------------------------------------
  // programs
  // ---------------------------------------------------------------
  localparam logic [5:0] PROG_EMERG = 6'h1a;
  localparam logic [5:0] PROG_HOME = 6'h19;
  localparam logic [5:0] PROG_BASE_MAX = 6'h1f;
  localparam logic [5:0] PROG_EXP_MAX = 6'h3f;

  // ---------------------------------------------------------------
  // timing and analog scaling
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int DEB_W = 8;
  localparam int ADC_W = 12;
  localparam logic [7:0] FEED_MAX_PCT = 8'hc8;
  localparam logic [7:0] FEED_SCALE = 8'hc9;
  localparam int FEED_SHIFT = 11;

  typedef struct packed {
    logic sel_inputs;
    logic feed_src;
    logic home_index;
    logic pause_open;
    logic home_open;
    logic start_fn;
    logic pause_fn;
    logic limit_fn;
    logic jog_fn;
    logic home_sw_fn;
    logic home_cmd_fn;
    logic emerg_fn;
    logic drive_fn;
  } ctrl_s;

  typedef struct packed {
    logic limit_fwd;
    logic limit_rev;
    logic jog_fwd;
    logic jog_rev;
    logic pause;
    logic home_switch;
    logic home_switch_enable_flag;
    logic drive_enable;
    logic kill_motion;
    logic hw_reset;
  } motion_s;

endpackage : dic_pkg
`default_nettype wire

// ===== discrete_input_conditioning.sv
// discrete input conditioning: debounce, dedicated functions, program select
// ---------------------------------------------------------------
// Functional notes
// [R1] a disabled dedicated input shows up as a general purpose input
// [R2] enabled drive-enable input enables and disables the drive
// [R3] enabled emergency return input launches program 26
// [R4] enabled home command input launches program 25
// [R5] home switch feeds homing; active open or closed, default closed
// [R6] pause input active open or closed, default closed, enabled
// [R7] both jog inputs share one enable, default enabled
// [R8] both travel limit inputs share one enable, default enabled
// [R9] start input function can be disabled, default enabled
// [R10] define-home, hw reset, kill each assignable to input 1..16 or off
// [R11] active define-home input takes current location as home
// [R12] active hardware reset input requests a hardware reset
// [R13] kill input halts program and holds position, jogs keep running
// [R14] analog input one as feedrate source maps 0..10 V to 0..200 %
// [R15] a change is accepted after staying stable for debounce ms
// [R16] home to index default on; off forces home switch flag off
// [R17] up to six select lines, input 16 msb down to input 11
// [R18] start with select-from-inputs runs the decoded program number
// [R19] outside settles select lines 2 ms before start
// [R20] without select-from-inputs start runs the default program
// [R21] programs 32..63 exist only with the expansion card
// [R22] inputs 11 and 12 act as interrupt inputs once program started
// [R23] default program limited to 0..31, or 0..63 with expansion
// [R24] debounce counts millisecond ticks and restarts on level change
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module discrete_input_conditioning #(
  parameter int TICK_CYCLES = dic_pkg::TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dic_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [dic_pkg::NUM_IN-1:0] pins,
  input wire logic expansion_present,
  input wire logic program_running,
  input wire logic [dic_pkg::ADC_W-1:0] analog_input_one,
  output dic_pkg::motion_s motion,
  output logic [dic_pkg::NUM_IN-1:0] gp_inputs,
  output logic interrupt_input_one,
  output logic interrupt_input_two,
  output logic run_request,
  output logic [5:0] run_program,
  output logic run_rejected,
  output logic define_home,
  output logic [7:0] feedrate_pct,
  output logic feedrate_active
);
  import dic_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  ctrl_s ctrl;
  logic [ASG_W-1:0] asg_defhome;
  logic [ASG_W-1:0] asg_hwrst;
  logic [ASG_W-1:0] asg_kill;
  logic [DEB_W-1:0] debounce_ms;
  logic [2:0] sel_lines;
  logic [5:0] default_prog;

  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [31:0] next_prdata;
  logic [5:0] prog_limit;
  logic [5:0] def_wr;

  // ---------------------------------------------------------------
  // input path state
  // ---------------------------------------------------------------
  logic [NUM_IN-1:0] sync1;
  logic [NUM_IN-1:0] sync2;
  logic exp1;
  logic exp_ok;
  logic [NUM_IN-1:0] corr;
  logic [NUM_IN-1:0] last_raw;
  logic [NUM_IN-1:0] deb;
  logic [NUM_IN-1:0] deb_prev;
  logic [DEB_W-1:0] cnt [NUM_IN];
  logic [TW-1:0] tick_cnt;
  logic tick;

  // returns the level of the input picked by an assignment, off when 0
  function automatic logic assigned_level(input logic [NUM_IN-1:0] d,
                                          input logic [ASG_W-1:0] a);
    logic [ASG_W-1:0] idx;
    idx = a - 5'h01;
    assigned_level = (a != ASG_OFF) && (a <= ASG_MAX) &&
                     d[idx[3:0]];
  endfunction : assigned_level

  // ---------------------------------------------------------------
  // apb slave, one cycle answer
  // ---------------------------------------------------------------
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_ASSIGN) ||
                   (paddr == ADDR_PROG) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_ANALOG);
  assign prog_limit = exp_ok ? PROG_EXP_MAX : PROG_BASE_MAX;
  assign def_wr = pwdata[PRG_DEF_LSB +: 6];

  always_comb begin
    next_prdata = 32'h00000000;
    case (paddr)
      ADDR_CTRL: next_prdata[CTRL_W-1:0] = ctrl;
      ADDR_ASSIGN: begin
        next_prdata[ASG_DEFHOME_LSB +: ASG_W] = asg_defhome;
        next_prdata[ASG_HWRST_LSB +: ASG_W] = asg_hwrst;
        next_prdata[ASG_KILL_LSB +: ASG_W] = asg_kill;
      end
      ADDR_PROG: begin
        next_prdata[PRG_DEB_LSB +: DEB_W] = debounce_ms;
        next_prdata[PRG_LINES_LSB +: 3] = sel_lines;
        next_prdata[PRG_DEF_LSB +: 6] = default_prog;
      end
      ADDR_STATUS: begin
        next_prdata[NUM_IN-1:0] = deb;
        next_prdata[ST_PROG_LSB +: 6] = run_program;
        next_prdata[ST_EXP_BIT] = exp_ok;
      end
      ADDR_ANALOG: begin
        next_prdata[ADC_W-1:0] = analog_input_one;
        next_prdata[AN_FEED_LSB +: 8] = feedrate_pct;
      end
      default: next_prdata = 32'h00000000;
    endcase
  end

  // pready rises at the edge that ends the setup cycle so the access edge always completes
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup && !addr_ok;
      if (rd_setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= ctrl_s'(CTRL_RESET);
      asg_defhome <= ASG_OFF;
      asg_hwrst <= ASG_OFF;
      asg_kill <= ASG_OFF;
      debounce_ms <= 8'h00;
      sel_lines <= 3'h0;
      default_prog <= 6'h00;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL: ctrl <= ctrl_s'(pwdata[CTRL_W-1:0]); // R1 R9
        ADDR_ASSIGN: begin
          asg_defhome <= pwdata[ASG_DEFHOME_LSB +: ASG_W]; // R10
          asg_hwrst <= pwdata[ASG_HWRST_LSB +: ASG_W]; // R10
          asg_kill <= pwdata[ASG_KILL_LSB +: ASG_W]; // R10
        end
        ADDR_PROG: begin
          debounce_ms <= pwdata[PRG_DEB_LSB +: DEB_W]; // R15
          sel_lines <= pwdata[PRG_LINES_LSB +: 3];
          // out-of-range default program saturates at the limit
          default_prog <= (def_wr > prog_limit) ? prog_limit : def_wr; // R23
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // synchronisers and millisecond tick
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      exp1 <= 1'b0;
      exp_ok <= 1'b0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      exp1 <= expansion_present;
      exp_ok <= exp1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TW'(TICK_CYCLES - 1)); // R24
      tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // polarity and debounce
  // ---------------------------------------------------------------
  // pin high means switch closed; active-open inputs are inverted here
  always_comb begin
    corr = sync2;
    corr[PIN_HOME_SW] = sync2[PIN_HOME_SW] ^ ctrl.home_open; // R5
    corr[PIN_PAUSE] = sync2[PIN_PAUSE] ^ ctrl.pause_open; // R6
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      last_raw <= '0;
      deb <= '0;
      deb_prev <= '0;
      for (int i = 0; i < NUM_IN; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      deb_prev <= deb;
      for (int i = 0; i < NUM_IN; i++) begin
        if (corr[i] != last_raw[i]) begin
          last_raw[i] <= corr[i];
          cnt[i] <= '0; // R24
        end else if (last_raw[i] == deb[i]) begin
          cnt[i] <= '0;
        end else if (cnt[i] >= debounce_ms) begin
          deb[i] <= last_raw[i]; // R15
        end else if (tick) begin
          cnt[i] <= cnt[i] + 1'b1; // R24
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // dedicated and assignable functions
  // ---------------------------------------------------------------
  logic sel_int_one;
  logic sel_int_two;
  assign sel_int_one = ctrl.sel_inputs && (sel_lines >= 3'h6);
  assign sel_int_two = ctrl.sel_inputs && (sel_lines >= 3'h5);

  always_ff @(posedge clk) begin
    if (rst) begin
      motion <= '0;
      gp_inputs <= '0;
      define_home <= 1'b0;
      interrupt_input_one <= 1'b0;
      interrupt_input_two <= 1'b0;
    end else begin
      motion.drive_enable <= ctrl.drive_fn ? deb[PIN_DRIVE] : 1'b1; // R2
      motion.limit_fwd <= ctrl.limit_fn && deb[PIN_LIM_FWD]; // R8
      motion.limit_rev <= ctrl.limit_fn && deb[PIN_LIM_REV]; // R8
      // jog motion is deliberately independent of the kill input
      motion.jog_fwd <= ctrl.jog_fn && deb[PIN_JOG_FWD]; // R7 R13
      motion.jog_rev <= ctrl.jog_fn && deb[PIN_JOG_REV]; // R7 R13
      motion.pause <= ctrl.pause_fn && deb[PIN_PAUSE]; // R6
      motion.home_switch <= ctrl.home_sw_fn && deb[PIN_HOME_SW]; // R5
      motion.home_switch_enable_flag <= ctrl.home_sw_fn &&
                                        ctrl.home_index; // R16
      motion.kill_motion <= assigned_level(deb, asg_kill); // R13
      motion.hw_reset <= assigned_level(deb, asg_hwrst); // R12
      define_home <= assigned_level(deb, asg_defhome) &&
                     !assigned_level(deb_prev, asg_defhome); // R11
      gp_inputs <= deb & ~(DEDICATED_MASK &
                   {6'h00, ctrl.emerg_fn, ctrl.pause_fn, {2{ctrl.jog_fn}},
                    ctrl.home_cmd_fn, ctrl.home_sw_fn, ctrl.start_fn,
                    ctrl.drive_fn, {2{ctrl.limit_fn}}}); // R1
      // select lines borrow the interrupt pins until the program runs
      interrupt_input_one <= deb[PIN_INT_ONE] &&
                             (!sel_int_one || program_running); // R22
      interrupt_input_two <= deb[PIN_INT_TWO] &&
                             (!sel_int_two || program_running); // R22
    end
  end

  // ---------------------------------------------------------------
  // program launch
  // ---------------------------------------------------------------
  logic emerg_rise;
  logic home_rise;
  logic start_rise;
  logic [2:0] lines_used;
  logic [5:0] sel_value;
  logic [5:0] next_prog;
  logic launch;

  assign emerg_rise = ctrl.emerg_fn && deb[PIN_EMERG] &&
                      !deb_prev[PIN_EMERG];
  assign home_rise = ctrl.home_cmd_fn && deb[PIN_HOME_CMD] &&
                     !deb_prev[PIN_HOME_CMD];
  assign start_rise = ctrl.start_fn && deb[PIN_START] &&
                      !deb_prev[PIN_START]; // R9
  assign lines_used = (sel_lines > 3'h6) ? 3'h6 : sel_lines; // R17
  // input 16 is the msb; fewer lines shift the unused low pins out
  assign sel_value = deb[NUM_IN-1:SEL_LSB_PIN] >>
                     (3'h6 - lines_used); // R17 R18
  assign launch = emerg_rise || home_rise || start_rise;

  always_comb begin
    if (emerg_rise) begin
      next_prog = PROG_EMERG; // R3
    end else if (home_rise) begin
      next_prog = PROG_HOME; // R4
    end else if (ctrl.sel_inputs) begin
      next_prog = sel_value; // R18
    end else begin
      next_prog = default_prog; // R20
    end
  end

  // programs above 31 need the expansion card; otherwise refused
  always_ff @(posedge clk) begin
    if (rst) begin
      run_request <= 1'b0;
      run_rejected <= 1'b0;
      run_program <= 6'h00;
    end else begin
      run_request <= launch && (next_prog <= prog_limit); // R21
      run_rejected <= launch && (next_prog > prog_limit); // R21
      if (launch) begin
        run_program <= next_prog;
      end
    end
  end

  // ---------------------------------------------------------------
  // analog feedrate
  // ---------------------------------------------------------------
  logic [18:0] feed_prod;
  logic [7:0] feed_scaled;
  assign feed_prod = analog_input_one[ADC_W-2:0] * FEED_SCALE;
  assign feed_scaled = feed_prod[FEED_SHIFT +: 8];

  always_ff @(posedge clk) begin
    if (rst) begin
      feedrate_pct <= 8'h00;
      feedrate_active <= 1'b0;
    end else begin
      feedrate_active <= ctrl.feed_src; // R14
      // negative codes read as zero volts, full scale as 200 percent
      if (analog_input_one[ADC_W-1]) begin
        feedrate_pct <= 8'h00; // R14
      end else begin
        feedrate_pct <= (feed_scaled > FEED_MAX_PCT) ? FEED_MAX_PCT
                                                     : feed_scaled; // R14
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  emerg_launch_a: assert property (emerg_rise |=> run_request && // R3
      run_program == PROG_EMERG) else $error("emergency launch wrong");
  home_launch_a: assert property (home_rise && !emerg_rise |=> // R4
      run_program == PROG_HOME) else $error("home launch wrong");
  default_launch_a: assert property (start_rise && !emerg_rise && // R20
      !home_rise && !ctrl.sel_inputs |=>
      run_program == $past(default_prog)) else $error("default wrong");
  decode_launch_a: assert property (start_rise && !emerg_rise && // R18
      !home_rise && ctrl.sel_inputs && lines_used == 3'h6 |=>
      run_program == $past(deb[15:10])) else $error("decode wrong");
  debounce_wait_a: assert property ( // R15
      deb[PIN_START] != $past(deb[PIN_START]) |->
      $past(cnt[PIN_START]) >= $past(debounce_ms))
      else $error("early accept");
  limit_off_a: assert property (!ctrl.limit_fn |=> // R8
      !motion.limit_fwd && !motion.limit_rev) else $error("limit leak");
  jog_kill_a: assert property (ctrl.jog_fn ##1 ctrl.jog_fn |-> // R13
      motion.jog_fwd == $past(deb[PIN_JOG_FWD])) else $error("jog lost");
  home_flag_a: assert property (!ctrl.home_index |=> // R16
      !motion.home_switch_enable_flag) else $error("home flag on");
  expansion_a: assert property (run_request && !$past(exp_ok) |-> // R21
      !run_program[5]) else $error("program above 31 ran");
  int_hold_a: assert property (sel_int_one && !program_running |=> // R22
      !interrupt_input_one) else $error("interrupt leaked");

endmodule : discrete_input_conditioning
`default_nettype wire

// ===== field_switches.sv
// field switch and wiring model that drives the raw discrete inputs
`timescale 1ns/1ps
`default_nettype none
module field_switches (
  input wire logic clk,
  input wire logic [15:0] closed,
  input wire logic [15:0] chatter,
  output logic [15:0] pins
);
  logic phase = 1'b0;
  // a chattering contact flips every cycle, so it never looks stable
  always @(posedge clk) begin
    phase <= ~phase;
    pins <= closed ^ (chatter & {16{phase}});
  end
endmodule : field_switches
`default_nettype wire

// ===== discrete_input_conditioning_tb.sv
// self-checking bench for the discrete input conditioning block
`timescale 1ns/1ps
`default_nettype none
module discrete_input_conditioning_tb;
  import dic_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, feedrate_pct;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] closed, chatter, pins, gp_inputs;
  logic expansion_present, program_running, feedrate_active, define_home;
  logic int_one, int_two, run_request, run_rejected;
  logic [11:0] analog_input_one;
  logic [5:0] run_program;
  motion_s motion;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int home_pulses = 0;
  int seed = 25091;
  int v;
  logic [32:0] rd_q[$];
  logic [6:0] run_q[$];

  discrete_input_conditioning #(.TICK_CYCLES(8))
    discrete_input_conditioning_inst (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .expansion_present(expansion_present),
    .program_running(program_running), .analog_input_one(analog_input_one),
    .motion(motion), .gp_inputs(gp_inputs), .interrupt_input_one(int_one),
    .interrupt_input_two(int_two), .run_request(run_request),
    .run_program(run_program), .run_rejected(run_rejected),
    .define_home(define_home), .feedrate_pct(feedrate_pct),
    .feedrate_active(feedrate_active));
  field_switches field_switches_inst (.clk(clk), .closed(closed),
    .chatter(chatter), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // compare and report
  // ---------------------------------------------------------------
  task automatic note(input logic ok, input logic [32:0] got, exp);
    checks_done++;
    if (!ok) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : note
  task automatic cmp_rd(input logic [32:0] got, exp);
    note(got === exp, got, exp);
  endtask : cmp_rd
  task automatic cmp_run(input logic [6:0] got, exp);
    note(got === exp, {26'h0, got}, {26'h0, exp});
  endtask : cmp_run
  task automatic cmp_bit(input logic got, exp);
    note(got === exp, {32'h0, got}, {32'h0, exp});
  endtask : cmp_bit
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // outputs are watched here; every result takes the oldest note
  always @(posedge clk) begin
    cycles++;
    if (!rst && psel && penable && pready === 1'b1 && !pwrite)
      cmp_rd({pslverr, prdata}, rd_q.size() ? rd_q.pop_front() : 33'bx);
    if (!rst && (run_request === 1'b1 || run_rejected === 1'b1))
      cmp_run({run_rejected, run_program},
              run_q.size() ? run_q.pop_front() : 7'bx);
    if (!rst && define_home === 1'b1)
      home_pulses++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only pready or the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never reassigns psel in this step
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
    rd_q.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic press(input int idx, hold, input logic ev,
                       input logic [6:0] e);
    if (ev)
      run_q.push_back(e);
    closed[idx] <= 1'b1;
    tick(hold);
    closed[idx] <= 1'b0;
    tick(hold);
  endtask : press

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    closed = 16'h0000;
    chatter = 16'h0000;
    expansion_present = 1'b0;
    program_running = 1'b0;
    analog_input_one = 12'h000;
    tick(6);
    rst <= 1'b0;
    tick(2);
    rd(ADDR_CTRL, {19'h0, CTRL_RESET}, 1'b0);
    rd(ADDR_ASSIGN, 32'h0, 1'b0);
    rd(8'h14, 32'h0, 1'b1);
    cmp_bit(motion.drive_enable, 1'b0);
    press(PIN_EMERG, 12, 1'b1, {1'b0, PROG_EMERG});
    press(PIN_HOME_CMD, 12, 1'b1, {1'b0, PROG_HOME});
    $display("test reset and launches done");
    wr(ADDR_CTRL, 32'h047d);
    press(PIN_EMERG, 12, 1'b0, 7'h0);
    closed[PIN_START] <= 1'b1;
    tick(10);
    cmp_bit(gp_inputs[PIN_START], 1'b1);
    closed[PIN_START] <= 1'b0;
    closed[PIN_JOG_FWD] <= 1'b1;
    closed[PIN_LIM_REV] <= 1'b1;
    closed[PIN_DRIVE] <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL, k ? 32'h04ff : 32'h03cf);
      tick(8);
      cmp_bit(motion.drive_enable, 1'b1);
      cmp_bit(motion.jog_fwd, k[0]);
      cmp_bit(motion.limit_rev, k[0]);
      cmp_bit(gp_inputs[PIN_JOG_FWD], !k[0]);
      cmp_bit(motion.home_switch, !k[0]);
      cmp_bit(motion.pause, !k[0]);
      cmp_bit(motion.home_switch_enable_flag, k[0]);
    end
    $display("test enables and polarity done");
    wr(ADDR_PROG, 32'h0005_0000);
    press(PIN_START, 12, 1'b1, 7'h05);
    wr(ADDR_PROG, 32'h0028_0000);
    rd(ADDR_PROG, 32'h001f_0000, 1'b0);
    r = $random(seed) & 32'h001f1f1f;
    wr(ADDR_ASSIGN, r);
    rd(ADDR_ASSIGN, r, 1'b0);
    wr(ADDR_ASSIGN, 32'h000d_0e0f);
    closed[15:12] <= 4'h7;
    tick(10);
    cmp_bit(motion.kill_motion, 1'b1);
    cmp_bit(motion.jog_fwd, 1'b1);
    cmp_bit(motion.hw_reset, 1'b1);
    closed[15:12] <= 4'h0;
    tick(10);
    cmp_bit(motion.kill_motion, 1'b0);
    cmp_bit(motion.hw_reset, 1'b0);
    wr(ADDR_ASSIGN, 32'h0);
    $display("test assignable inputs done");
    wr(ADDR_CTRL, 32'h0cff);
    repeat (4) begin
      r = $random(seed);
      analog_input_one <= r[11:0];
      v = r[11] ? 0 : (int'(r[10:0]) * int'(FEED_SCALE)) >> FEED_SHIFT;
      tick(4);
      rd(ADDR_ANALOG, {8'h0, v[7:0], 4'h0, r[11:0]}, 1'b0);
      cmp_bit(feedrate_active, 1'b1);
      cmp_rd({25'h0, feedrate_pct}, {25'h0, v[7:0]});
    end
    wr(ADDR_CTRL, 32'h14ff);
    wr(ADDR_PROG, 32'h0000_0300);
    closed[15:14] <= 2'h3;
    tick(20);
    press(PIN_START, 12, 1'b1, 7'h06);
    wr(ADDR_PROG, 32'h0000_0600);
    closed[15:10] <= 6'h2b;
    tick(20);
    cmp_bit(int_one, 1'b0);
    cmp_bit(int_two, 1'b0);
    press(PIN_START, 12, 1'b1, 7'h6b);
    expansion_present <= 1'b1;
    tick(4);
    press(PIN_START, 12, 1'b1, 7'h2b);
    program_running <= 1'b1;
    tick(4);
    cmp_bit(int_one, 1'b1);
    cmp_bit(int_two, 1'b1);
    $display("test program select done");
    closed <= 16'h0000;
    wr(ADDR_CTRL, 32'h04ff);
    wr(ADDR_PROG, 32'h0007_0003);
    press(PIN_START, 10, 1'b0, 7'h0);
    run_q.push_back(7'h07);
    chatter[PIN_START] <= 1'b1;
    closed[PIN_START] <= 1'b1;
    tick(40);
    chatter[PIN_START] <= 1'b0;
    tick(60);
    closed[PIN_START] <= 1'b0;
    tick(60);
    $display("test debounce done");
    cmp_bit(home_pulses == 1, 1'b1);
    cmp_bit(run_q.size() == 0, 1'b1);
    tally_and_finish();
  end
endmodule : discrete_input_conditioning_tb
`default_nettype wire
